/* hdl/mrcd_decoder.sv */
module mrcd_decoder
  import mrcd_pkg::*;
#(
  parameter logic [39:0] MAKER_ID = 40'h4D_41_4B_45_52, // Arbitrary value
  parameter logic [39:0] MODEL_ID = 40'h30_30_30_30_31, // Arbitrary value
  parameter logic [3:0]  SW_MAJOR = 4'h1,
  parameter logic [3:0]  SW_MINOR = 4'h0
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        remote_i,
  input  wire logic        listener_i,
  input  wire logic        dev_clear_i,
  input  wire logic        cal_enable_i,
  input  wire logic        cal_verify_i,
  input  wire logic [2:0]  cal_step_i,
  input  wire logic        self_test_i,
  input  wire logic        rear_input_i,
  input  wire logic [3:0]  auto_range_i,
  input  wire logic [31:0] reading_i,
  input  wire logic        over_dc_i,
  input  wire logic        over_ac_i,
  output logic      [2:0]  func_o,
  output logic      [3:0]  range_o,
  output logic             display_blank_o,
  output logic             annun_flash_o,
  output logic             offset_on_o,
  output logic      [31:0] offset_value_o,
  output logic             cal_store_o,
  output logic             cal_converter_o,
  output logic             cal_hf_ac_o,
  output logic             cal_erase_o,
  output logic             out_eoi_o
);

  logic [7:0]  a_q;
  logic        w_q;
  logic        v_q;
  logic        cmd_go;
  logic        clr;
  mrcd_cmd_e   op;
  logic [2:0]  fsel;
  logic        cal_op;
  logic [31:0] rd_d;
  logic [2:0]  func_q;
  logic [3:0]  range_q;
  logic [3:0]  range_d;
  logic        blank_q;
  logic        flash_q;
  logic        off_on_q;
  logic [31:0] off_val_q;
  logic [2:0]  off_func_q;
  logic [31:0] setup_q;
  logic [5:0]  srq_q;
  logic [7:0]  err_q;
  logic        erase_pend_q;
  logic [3:0]  cal_pulse_q;
  logic        eoi_q;
  logic [4:0]  olen_q;
  logic [4:0]  olen_d;
  logic        eoi_d;
  mrcd_char_t  obuf_q [0:19];
  mrcd_char_t  obuf_d [0:19];
  mrcd_char_t  umsg_q [0:15];
  logic [3:0]  rng_use;
  logic [1:0]  rate;
  logic [2:0]  trig;
  logic        suffix;
  logic [2:0]  term;
  logic        manual;

  assign rate   = setup_q[1:0];
  assign trig   = setup_q[6:4];
  assign suffix = setup_q[8];
  assign term   = setup_q[14:12];
  assign manual = setup_q[16];

  // AHB-Lite address phase capture
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      a_q <= 8'h00;
      w_q <= 1'b0;
      v_q <= 1'b0;
    end else if (hready) begin
      a_q <= haddr;
      w_q <= hwrite;
      v_q <= hsel && htrans[1] && (hsize == 3'h2);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign cmd_go = v_q && w_q && (a_q == `MRCD_A_CMD)
                  && remote_i && listener_i;
  assign op     = mrcd_cmd_e'(hwdata[4:0]);
  assign fsel   = (hwdata[10:8] == `MRCD_F_ZERO) ? `MRCD_F_DCV : hwdata[10:8];
  assign clr    = dev_clear_i || (cmd_go && op == MRCD_CLEAR);
  assign cal_op = cmd_go && (op == MRCD_CAL_STORE || op == MRCD_CAL_CONV
                  || op == MRCD_CAL_HF_AC);

  // Automatic range adjustment on function select
  always_comb begin
    range_d = range_q;
    if (fsel == `MRCD_F_ACMA) begin
      range_d = `MRCD_R_FIVE;
    end else if (fsel == `MRCD_F_DCMA) begin
      if (range_q == `MRCD_R_EIGHT) begin
        range_d = `MRCD_R_FOUR;
      end else if (range_q >= `MRCD_R_ONE && range_q <= `MRCD_R_SIX) begin
        range_d = `MRCD_R_FIVE;
      end
    end else begin
      if ((func_q == `MRCD_F_OHM2 || func_q == `MRCD_F_OHM4)
          && range_q == `MRCD_R_SIX && fsel != func_q) begin
        range_d = `MRCD_R_FIVE;
      end
      if (range_q == `MRCD_R_EIGHT
          && (fsel == `MRCD_F_ACV || fsel == `MRCD_F_OHM2)) begin
        range_d = `MRCD_R_ONE;
      end
    end
  end

  // Function and range; a select otherwise only clears erase_pend_q
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      func_q  <= `MRCD_F_DCV;
      range_q <= `MRCD_R_ONE;
    end else if (clr) begin
      func_q  <= `MRCD_F_DCV;
      range_q <= `MRCD_R_ONE;
    end else if (cmd_go && op == MRCD_FUNC) begin
      func_q  <= fsel;
      range_q <= range_d;
    end else if (!manual) begin
      range_q <= auto_range_i;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      off_on_q   <= 1'b0;
      off_val_q  <= 32'h0000_0000;
      off_func_q <= `MRCD_F_DCV;
    end else if (clr) begin
      off_on_q <= 1'b0;
    end else if (cmd_go && op == MRCD_OFF_CAPTURE) begin
      off_on_q   <= 1'b1;
      off_val_q  <= reading_i;
      off_func_q <= func_q;
    end else if (cmd_go && op == MRCD_OFF_CANCEL) begin
      off_on_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      blank_q <= 1'b0;
      flash_q <= 1'b0;
    end else begin
      if (clr) begin
        blank_q <= 1'b0;
      end else if (cmd_go && op == MRCD_DISP_BLANK) begin
        blank_q <= 1'b1;
      end else if (cmd_go && op == MRCD_DISP_NORM) begin
        blank_q <= 1'b0;
      end
      flash_q <= (func_q == `MRCD_F_DCV && over_dc_i)
                 || (func_q == `MRCD_F_ACV && over_ac_i);
    end
  end

  // Calibration pulses: store, converter, HF AC, erase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_pulse_q  <= 4'h0;
      erase_pend_q <= 1'b0;
    end else begin
      cal_pulse_q <= 4'h0;
      if (clr) begin
        erase_pend_q <= 1'b0;
      end else if (cmd_go) begin
        erase_pend_q <= (op == MRCD_CAL_ERASE);
        if (cal_enable_i) begin
          cal_pulse_q[0] <= (op == MRCD_CAL_STORE);
          cal_pulse_q[1] <= (op == MRCD_CAL_CONV);
          cal_pulse_q[2] <= (op == MRCD_CAL_HF_AC);
          cal_pulse_q[3] <= (op == MRCD_CAL_STORE) && erase_pend_q;
        end
      end
    end
  end

  // Error register; a new error wins over a clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err_q <= `MRCD_ERR_NONE;
    end else if (cal_op && !cal_enable_i) begin
      err_q <= `MRCD_ERR_CAL;
    end else if (cmd_go && hwdata[4:0] > `MRCD_OP_CLEAR) begin
      err_q <= `MRCD_ERR_CMD;
    end else if (clr) begin
      err_q <= `MRCD_ERR_NONE;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      setup_q <= `MRCD_SETUP_RST;
      srq_q   <= `MRCD_SRQ_RST;
    end else if (clr) begin
      setup_q <= `MRCD_SETUP_RST;
      srq_q   <= `MRCD_SRQ_RST;
    end else if (v_q && w_q && a_q == `MRCD_A_SETUP) begin
      setup_q <= hwdata & 32'h0001_7173;
    end else if (v_q && w_q && a_q == `MRCD_A_SRQ && hwdata[5:0] <= 6'h3F) begin
      srq_q <= hwdata[5:0] & 6'h3D;
    end
  end

  // User message words in calibration memory
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_umsg
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          umsg_q[gi] <= 8'h00;
        end else if (cal_pulse_q[3]) begin
          umsg_q[gi] <= 8'h00;
        end else if (v_q && w_q && a_q == `MRCD_A_UMSG + 8'(4 * (gi / 4))) begin
          umsg_q[gi] <= hwdata[8 * (gi % 4) +: 8];
        end
      end
    end
  endgenerate

  assign rng_use = manual ? range_q : auto_range_i;

  function automatic mrcd_char_t dig(input logic [3:0] d);
    return `MRCD_CH_0 + {4'h0, d};
  endfunction

  // Query string plus terminators
  always_comb begin
    logic [4:0] n;
    n = 5'd0;
    for (int i = 0; i < 20; i++) begin
      obuf_d[i] = obuf_q[i];
    end
    olen_d = olen_q;
    eoi_d  = eoi_q;
    obuf_d[0] = `MRCD_CH_1;
    obuf_d[1] = `MRCD_CH_0;
    n = 5'd4;
    case (op)
      MRCD_Q_CONFIG: begin
        obuf_d[0] = self_test_i ? dig(`MRCD_F_SELF) : dig({1'b0, func_q});
        obuf_d[1] = dig(rng_use);
        obuf_d[2] = dig({2'b00, rate});
        obuf_d[3] = dig({1'b0, trig});
      end
      MRCD_Q_SRQ: begin
        obuf_d[0] = dig(4'(srq_q / 6'd10));
        obuf_d[1] = dig(4'(srq_q % 6'd10));
        n = 5'd2;
      end
      MRCD_Q_UMSG: begin
        for (int i = 0; i < 16; i++) begin
          obuf_d[i] = umsg_q[i];
        end
        n = 5'd16;
      end
      MRCD_Q_CAL: begin
        obuf_d[2] = dig({3'b000, cal_verify_i});
        obuf_d[3] = dig(cal_enable_i ? {1'b0, cal_step_i} : 4'h0);
      end
      MRCD_Q_IRO: begin
        obuf_d[1] = dig({3'b000, rear_input_i});
        obuf_d[2] = dig({3'b000, manual});
        obuf_d[3] = dig({3'b000, off_on_q});
      end
      MRCD_Q_SUFTERM: begin
        obuf_d[2] = dig({3'b000, suffix});
        obuf_d[3] = dig({1'b0, term});
      end
      MRCD_Q_ERROR: begin
        obuf_d[2] = dig(err_q[7:4]);
        obuf_d[3] = dig(err_q[3:0]);
      end
      MRCD_Q_IDENT: begin
        for (int i = 0; i < 5; i++) begin
          obuf_d[i]     = MAKER_ID[8 * (4 - i) +: 8];
          obuf_d[i + 6] = MODEL_ID[8 * (4 - i) +: 8];
        end
        obuf_d[5]  = `MRCD_CH_COMA;
        obuf_d[11] = `MRCD_CH_COMA;
        obuf_d[12] = `MRCD_CH_0;
        obuf_d[13] = `MRCD_CH_COMA;
        obuf_d[14] = `MRCD_CH_V;
        obuf_d[15] = dig(SW_MAJOR);
        obuf_d[16] = `MRCD_CH_DOT;
        obuf_d[17] = dig(SW_MINOR);
        n = 5'd18;
      end
      default: begin
        n = 5'd0;
      end
    endcase
    case (term)
      3'h0, 3'h1, 3'h2, 3'h3: begin
        obuf_d[n] = `MRCD_CH_CR;
        obuf_d[5'(n + 5'd1)] = (term < 3'h2) ? `MRCD_CH_LF : 8'h00;
      end
      3'h4, 3'h5: begin
        obuf_d[n] = `MRCD_CH_LF;
      end
      default: begin
      end
    endcase
    olen_d = n + ((term < 3'h2) ? 5'd2 : (term < 3'h6) ? 5'd1 : 5'd0);
    eoi_d  = (term == 3'h0) || (term == 3'h2) || (term == 3'h4);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      olen_q <= 5'd0;
      eoi_q  <= 1'b0;
      for (int i = 0; i < 20; i++) begin
        obuf_q[i] <= 8'h00;
      end
    end else if (clr) begin
      olen_q <= 5'd0;
    end else if (cmd_go && op >= MRCD_Q_CONFIG && op <= MRCD_Q_IDENT) begin
      olen_q <= olen_d;
      eoi_q  <= eoi_d;
      for (int i = 0; i < 20; i++) begin
        obuf_q[i] <= obuf_d[i];
      end
    end
  end

  // Read mux, registered at the address phase
  always_comb begin
    rd_d = 32'h0000_0000;
    case (haddr)
      `MRCD_A_SETUP:  rd_d = setup_q;
      `MRCD_A_STATUS: rd_d = {err_q, 5'h00, off_func_q, 4'h0, range_q,
                              1'b0, func_q, erase_pend_q, flash_q, off_on_q, blank_q};
      `MRCD_A_SRQ:    rd_d = {26'h0, srq_q};
      `MRCD_A_OFFSET: rd_d = off_val_q;
      `MRCD_A_OUTLEN: rd_d = {26'h0, eoi_q, olen_q};
      default: begin
        for (int i = 0; i < 5; i++) begin
          if (haddr == `MRCD_A_OBUF + 8'(4 * i)) begin
            rd_d = {obuf_q[4*i+3], obuf_q[4*i+2], obuf_q[4*i+1], obuf_q[4*i]};
          end
        end
        for (int i = 0; i < 4; i++) begin
          if (haddr == `MRCD_A_UMSG + 8'(4 * i)) begin
            rd_d = {umsg_q[4*i+3], umsg_q[4*i+2], umsg_q[4*i+1], umsg_q[4*i]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= rd_d;
    end
  end

  assign func_o          = func_q;
  assign range_o         = range_q;
  assign display_blank_o = blank_q;
  assign annun_flash_o   = flash_q;
  assign offset_on_o     = off_on_q;
  assign offset_value_o  = off_val_q;
  assign cal_store_o     = cal_pulse_q[0];
  assign cal_converter_o = cal_pulse_q[1];
  assign cal_hf_ac_o     = cal_pulse_q[2];
  assign cal_erase_o     = cal_pulse_q[3];
  assign out_eoi_o       = eoi_q;

  sequence s_erase_then_store;
    cmd_go && op == MRCD_CAL_STORE && cal_enable_i && erase_pend_q && !clr;
  endsequence

  sequence s_memory_wiped;
    cal_erase_o ##1 umsg_q[0] == 8'h00;
  endsequence

  a_offset_capture: assert property (@(posedge clk) disable iff (!reset_n)
    cmd_go && op == MRCD_OFF_CAPTURE && !clr |=> off_on_q && off_val_q == $past(reading_i))
    else $error("offset not captured");
  a_offset_clear: assert property (@(posedge clk) disable iff (!reset_n)
    clr |=> !off_on_q) else $error("offset survives clear");
  a_cal_gate: assert property (@(posedge clk) disable iff (!reset_n)
    cal_op && !cal_enable_i |=> cal_pulse_q == 4'h0 && err_q == `MRCD_ERR_CAL)
    else $error("cal command without cal mode");
  a_erase_store: assert property (@(posedge clk) disable iff (!reset_n)
    s_erase_then_store |=> s_memory_wiped)
    else $error("erase sequence failed");
  a_blank_clear: assert property (@(posedge clk) disable iff (!reset_n)
    clr |=> !blank_q) else $error("display still blank after clear");
  a_func_zero: assert property (@(posedge clk) disable iff (!reset_n)
    cmd_go && op == MRCD_FUNC && hwdata[10:8] == 3'h0 && !clr |=> func_q == `MRCD_F_DCV)
    else $error("function zero not dc volts");
  a_acma_range: assert property (@(posedge clk) disable iff (!reset_n)
    cmd_go && op == MRCD_FUNC && fsel == `MRCD_F_ACMA && !clr |=> range_q == `MRCD_R_FIVE)
    else $error("ac milliamps range wrong");
  a_dcma_low: assert property (@(posedge clk) disable iff (!reset_n)
    cmd_go && op == MRCD_FUNC && fsel == `MRCD_F_DCMA && range_q == `MRCD_R_EIGHT
    && !clr |=> range_q == `MRCD_R_FOUR) else $error("dc milliamps range wrong");
  a_remote_gate: assert property (@(posedge clk) disable iff (!reset_n)
    v_q && w_q && !(remote_i && listener_i) && !dev_clear_i |=> $stable(func_q)
    && $stable(olen_q)) else $error("command taken while not addressed");
  a_config_len: assert property (@(posedge clk) disable iff (!reset_n)
    cmd_go && op == MRCD_Q_CONFIG && !clr && term == 3'h0 |=> olen_q == 5'd6)
    else $error("config reply length wrong");

endmodule // mrcd_decoder

/* shared/mrcd_regs.svh */
`ifndef MRCD_REGS_SVH
`define MRCD_REGS_SVH

// Register byte addresses
`define MRCD_A_CMD       8'h00
`define MRCD_A_SETUP     8'h04
`define MRCD_A_STATUS    8'h08
`define MRCD_A_SRQ       8'h0C
`define MRCD_A_OFFSET    8'h10
`define MRCD_A_OUTLEN    8'h14
`define MRCD_A_OBUF      8'h20
`define MRCD_A_UMSG      8'h40
`define MRCD_OBUF_WORDS  5
`define MRCD_UMSG_WORDS  4

// Command opcodes, CMD[4:0]; function argument in CMD[10:8]
`define MRCD_OP_OFF_CANCEL  5'h00
`define MRCD_OP_OFF_CAPTURE 5'h01
`define MRCD_OP_CAL_STORE   5'h02
`define MRCD_OP_CAL_CONV    5'h03
`define MRCD_OP_CAL_HF_AC   5'h04
`define MRCD_OP_CAL_ERASE   5'h05
`define MRCD_OP_DISP_NORM   5'h06
`define MRCD_OP_DISP_BLANK  5'h07
`define MRCD_OP_FUNC        5'h08
`define MRCD_OP_Q_CONFIG    5'h09
`define MRCD_OP_Q_SRQ       5'h0A
`define MRCD_OP_Q_UMSG      5'h0B
`define MRCD_OP_Q_CAL       5'h0C
`define MRCD_OP_Q_IRO       5'h0D
`define MRCD_OP_Q_SUFTERM   5'h0E
`define MRCD_OP_Q_ERROR     5'h0F
`define MRCD_OP_Q_IDENT     5'h10
`define MRCD_OP_CLEAR       5'h11

// Function and range codes
`define MRCD_F_ZERO  3'h0
`define MRCD_F_DCV   3'h1
`define MRCD_F_ACV   3'h2
`define MRCD_F_OHM2  3'h3
`define MRCD_F_OHM4  3'h4
`define MRCD_F_DCMA  3'h5
`define MRCD_F_ACMA  3'h6
`define MRCD_F_SELF  4'h9
`define MRCD_R_ONE   4'h1
`define MRCD_R_FOUR  4'h4
`define MRCD_R_FIVE  4'h5
`define MRCD_R_SIX   4'h6
`define MRCD_R_EIGHT 4'h8

// Reset values and error codes (two BCD digits)
`define MRCD_SETUP_RST 32'h0000_0000
`define MRCD_SRQ_RST   6'h00
`define MRCD_ERR_NONE  8'h00
`define MRCD_ERR_CAL   8'h51
`define MRCD_ERR_CMD   8'h71

// Characters
`define MRCD_CH_0    8'h30
`define MRCD_CH_1    8'h31
`define MRCD_CH_V    8'h56
`define MRCD_CH_DOT  8'h2E
`define MRCD_CH_COMA 8'h2C
`define MRCD_CH_CR   8'h0D
`define MRCD_CH_LF   8'h0A

`endif

/* shared/mrcd_pkg.sv */
`include "mrcd_regs.svh"
package mrcd_pkg;
  typedef logic [7:0] mrcd_char_t;
  typedef enum logic [4:0] {
    MRCD_OFF_CANCEL  = `MRCD_OP_OFF_CANCEL,
    MRCD_OFF_CAPTURE = `MRCD_OP_OFF_CAPTURE,
    MRCD_CAL_STORE   = `MRCD_OP_CAL_STORE,
    MRCD_CAL_CONV    = `MRCD_OP_CAL_CONV,
    MRCD_CAL_HF_AC   = `MRCD_OP_CAL_HF_AC,
    MRCD_CAL_ERASE   = `MRCD_OP_CAL_ERASE,
    MRCD_DISP_NORM   = `MRCD_OP_DISP_NORM,
    MRCD_DISP_BLANK  = `MRCD_OP_DISP_BLANK,
    MRCD_FUNC        = `MRCD_OP_FUNC,
    MRCD_Q_CONFIG    = `MRCD_OP_Q_CONFIG,
    MRCD_Q_SRQ       = `MRCD_OP_Q_SRQ,
    MRCD_Q_UMSG      = `MRCD_OP_Q_UMSG,
    MRCD_Q_CAL       = `MRCD_OP_Q_CAL,
    MRCD_Q_IRO       = `MRCD_OP_Q_IRO,
    MRCD_Q_SUFTERM   = `MRCD_OP_Q_SUFTERM,
    MRCD_Q_ERROR     = `MRCD_OP_Q_ERROR,
    MRCD_Q_IDENT     = `MRCD_OP_Q_IDENT,
    MRCD_CLEAR       = `MRCD_OP_CLEAR
  } mrcd_cmd_e;
endpackage

/* sim/mrcd_ctrl_model.sv */
module mrcd_ctrl_model (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic want_remote,
  input  wire logic clr_req,
  output logic      remote_i,
  output logic      listener_i,
  output logic      dev_clear_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // Remote and listen addressing come up together, one cycle after want_remote
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      remote_i   <= 1'b0;
      listener_i <= 1'b0;
    end else begin
      remote_i   <= want_remote;
      listener_i <= want_remote;
    end
  end

  // Bus device clear as a single-cycle pulse
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dev_clear_i <= 1'b0;
    end else begin
      dev_clear_i <= clr_req & ~dev_clear_i;
    end
  end
endmodule // mrcd_ctrl_model

/* sim/test_meter_remote_command_decoder.sv */
`include "mrcd_regs.svh"
module test_meter_remote_command_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, reset_n, hsel, hwrite, hreadyout, hresp, want_remote, clr_req;
  logic        remote_i, listener_i, dev_clear_i, cal_enable_i, cal_verify_i;
  logic        self_test_i, rear_input_i, over_dc_i, over_ac_i, display_blank_o;
  logic        annun_flash_o, offset_on_o, cal_store_o, cal_converter_o;
  logic        cal_hf_ac_o, cal_erase_o, out_eoi_o;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize, cal_step_i, func_o;
  logic [3:0]  auto_range_i, range_o;
  logic [31:0] hwdata, hrdata, reading_i, offset_value_o, rd;
  logic [15:0] tab [7] = '{16'h8554, 16'h3555, 16'h1665, 16'h8221, 16'h8331,
                           16'h6445, 16'h2012};
  int          n_fail, checked;

  mrcd_decoder #(.MAKER_ID(40'h41_42_43_44_45)) dut (.clk, .reset_n, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .remote_i, .listener_i, .dev_clear_i, .cal_enable_i, .cal_verify_i, .cal_step_i,
    .self_test_i, .rear_input_i, .auto_range_i, .reading_i, .over_dc_i, .over_ac_i,
    .func_o, .range_o, .display_blank_o, .annun_flash_o, .offset_on_o, .offset_value_o,
    .cal_store_o, .cal_converter_o, .cal_hf_ac_o, .cal_erase_o, .out_eoi_o);

  mrcd_ctrl_model ctrl (.clk, .reset_n, .want_remote, .clr_req, .remote_i, .listener_i,
    .dev_clear_i);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("n_fail=%0d checked=%0d", n_fail, checked);
    if (n_fail == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  // One single word transfer; an idle cycle always precedes it
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    rd = hrdata;
    if (n >= 40) begin
      n_fail++;
      print_verdict();
    end
  endtask

  task automatic cmd(input logic [4:0] op, input logic [2:0] f);
    bus(1'b1, `MRCD_A_CMD, {21'h0, f, 3'h0, op});
    #1;
  endtask

  task automatic query(input logic [4:0] op, input logic [31:0] w0, input logic [15:0] w1,
                       input logic [5:0] len);
    cmd(op, 3'h0);
    bus(1'b0, `MRCD_A_OBUF, 32'h0);
    chk(rd, w0);
    bus(1'b0, `MRCD_A_OBUF + 8'h04, 32'h0);
    if (len[4:0] > 5'h4) begin
      chk({16'h0, rd[15:0] & ((len[4:0] > 5'h5) ? 16'hFFFF : 16'h00FF)}, {16'h0, w1});
    end
    bus(1'b0, `MRCD_A_OUTLEN, 32'h0);
    chk({26'h0, rd[5:0]}, {26'h0, len});
  endtask

  // Autoranger picks r, then autorange is switched off to hold it
  task automatic setrange(input logic [3:0] r);
    auto_range_i <= r;
    bus(1'b1, `MRCD_A_SETUP, 32'h0);
    repeat (3) @(posedge clk);
    bus(1'b1, `MRCD_A_SETUP, 32'h0001_0000);
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  initial begin
    {hsel, haddr, htrans, hwrite, hwdata, want_remote, clr_req} = '0;
    {cal_enable_i, cal_verify_i, cal_step_i, self_test_i, rear_input_i} = '0;
    {reading_i, over_dc_i, over_ac_i, reset_n, n_fail, checked} = '0;
    hsize = 3'h2;
    auto_range_i = 4'h1;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    settle(2);
    chk(32'(func_o), 32'h1);
    chk(32'(range_o), 32'h1);
    chk(32'(display_blank_o), 32'h0);
    chk(32'(offset_on_o), 32'h0);
    cmd(`MRCD_OP_DISP_BLANK, 3'h0);
    chk(32'(display_blank_o), 32'h0);
    want_remote <= 1'b1;
    settle(3);
    query(`MRCD_OP_Q_CONFIG, 32'h3030_3131, 16'h0A0D, 6'h26);
    chk(32'(hresp), 32'h0);
    query(`MRCD_OP_Q_SRQ, 32'h0A0D_3030, 16'h0, 6'h24);
    bus(1'b1, `MRCD_A_SRQ, 32'h21);
    query(`MRCD_OP_Q_SRQ, 32'h0A0D_3333, 16'h0, 6'h24);
    for (int i = 0; i < 7; i++) begin
      setrange(tab[i][15:12]);
      cmd(`MRCD_OP_FUNC, tab[i][10:8]);
      chk(32'(func_o), 32'(tab[i][7:4]));
      chk(32'(range_o), 32'(tab[i][3:0]));
    end
    bus(1'b1, `MRCD_A_SETUP, 32'h0);
    auto_range_i <= 4'h3;
    self_test_i <= 1'b1;
    settle(3);
    // Self-test configuration is read here and never loaded back
    query(`MRCD_OP_Q_CONFIG, 32'h3030_3339, 16'h0A0D, 6'h26);
    self_test_i <= 1'b0;
    reading_i <= 32'h0000_00A5;
    cmd(`MRCD_OP_OFF_CAPTURE, 3'h0);
    chk(offset_value_o, 32'h0000_00A5);
    reading_i <= 32'h0000_005A;
    cmd(`MRCD_OP_OFF_CAPTURE, 3'h0);
    chk(offset_value_o, 32'h0000_005A);
    query(`MRCD_OP_Q_IRO, 32'h3130_3031, 16'h0A0D, 6'h26);
    cmd(`MRCD_OP_OFF_CANCEL, 3'h0);
    chk(32'(offset_on_o), 32'h0);
    for (int i = 0; i < 2; i++) begin
      cmd(`MRCD_OP_OFF_CAPTURE, 3'h0);
      cmd(`MRCD_OP_DISP_BLANK, 3'h0);
      cmd(`MRCD_OP_FUNC, 3'h3);
      chk(32'(offset_on_o), 32'h1);
      if (i == 0) begin
        cmd(`MRCD_OP_CLEAR, 3'h0);
      end else begin
        clr_req <= 1'b1;
        @(posedge clk);
        clr_req <= 1'b0;
      end
      settle(3);
      chk(32'(offset_on_o), 32'h0);
      chk(32'(display_blank_o), 32'h0);
      chk(32'(func_o), 32'h1);
    end
    cmd(`MRCD_OP_DISP_BLANK, 3'h0);
    chk(32'(display_blank_o), 32'h1);
    over_dc_i <= 1'b1;
    settle(3);
    chk(32'(annun_flash_o), 32'h1);
    over_dc_i <= 1'b0;
    cmd(`MRCD_OP_FUNC, 3'h2);
    chk(32'(display_blank_o), 32'h1);
    over_ac_i <= 1'b1;
    settle(3);
    chk(32'(annun_flash_o), 32'h1);
    over_ac_i <= 1'b0;
    cmd(`MRCD_OP_DISP_NORM, 3'h0);
    chk(32'(display_blank_o), 32'h0);
    chk(32'(annun_flash_o), 32'h0);
    cmd(`MRCD_OP_CAL_STORE, 3'h0);
    chk(32'(cal_store_o), 32'h0);
    query(`MRCD_OP_Q_ERROR, 32'h3135_3031, 16'h0A0D, 6'h26);
    cal_enable_i <= 1'b1;
    cmd(`MRCD_OP_CAL_CONV, 3'h0);
    chk(32'(cal_converter_o), 32'h1);
    cmd(`MRCD_OP_CAL_HF_AC, 3'h0);
    chk(32'(cal_hf_ac_o), 32'h1);
    bus(1'b1, `MRCD_A_UMSG, 32'h4444_4444);
    cmd(`MRCD_OP_CAL_ERASE, 3'h0);
    cmd(`MRCD_OP_CAL_STORE, 3'h0);
    chk(32'({cal_store_o, cal_erase_o}), 32'h3);
    bus(1'b0, `MRCD_A_UMSG, 32'h0);
    chk(rd, 32'h0);
    cal_verify_i <= 1'b1;
    cal_step_i <= 3'h2;
    query(`MRCD_OP_Q_CAL, 32'h3231_3031, 16'h0A0D, 6'h26);
    cmd(5'h1F, 3'h0);
    query(`MRCD_OP_Q_ERROR, 32'h3137_3031, 16'h0A0D, 6'h26);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, `MRCD_A_UMSG + 8'(4 * k), 32'h4142_4340 + 32'(k));
    end
    query(`MRCD_OP_Q_UMSG, 32'h4142_4340, 16'h4341, 6'h32);
    for (int k = 2; k < 4; k++) begin
      bus(1'b0, `MRCD_A_OBUF + 8'(4 * k), 32'h0);
      chk(rd, 32'h4142_4340 + 32'(k));
    end
    bus(1'b1, `MRCD_A_SETUP, 32'h0000_5100);
    query(`MRCD_OP_Q_SUFTERM, 32'h3531_3031, 16'h000A, 6'h05);
    chk(32'(out_eoi_o), 32'h0);
    bus(1'b1, `MRCD_A_SETUP, 32'h0);
    query(`MRCD_OP_Q_IDENT, 32'h4443_4241, 16'h2C45, 6'h34);
    print_verdict();
  end
endmodule // test_meter_remote_command_decoder
